/* File: core/scrr_pkg.sv */
package scrr_pkg;
    // Register byte addresses (one aligned word each)
    localparam logic [7:0] ADDR_RX_STATUS   = 8'h04;
    localparam logic [7:0] ADDR_VECTOR      = 8'h08;
    localparam logic [7:0] ADDR_PENDING     = 8'h0c;
    localparam logic [7:0] ADDR_MODE_RB     = 8'h10;
    localparam logic [7:0] ADDR_VECTOR_WR   = 8'h20;
    localparam logic [7:0] ADDR_MODE_WR     = 8'h24;
    localparam logic [7:0] ADDR_EXT_CTRL    = 8'h28;
    localparam logic [7:0] ADDR_CHAN_SEL    = 8'h2c;
    localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h30;
    localparam logic [7:0] ADDR_IRQ_MASK    = 8'h34;
    // Field positions
    localparam int EXT_RB_BIT       = 6;
    localparam int PEND_A_LSB       = 3;
    localparam int PEND_B_LSB       = 0;
    localparam int VEC_STAT_LSB     = 1;
    localparam int MODE_PAR_SENSE   = 1;
    localparam int MODE_SYNC_LSB    = 4;
    // Sync-mode field encodings
    localparam logic [1:0] SYNC_8BIT  = 2'h0;
    localparam logic [1:0] SYNC_16BIT = 2'h1;
    localparam logic [1:0] SYNC_FRAME = 2'h2;
    localparam logic [1:0] SYNC_EXT   = 2'h3;
    localparam logic [7:0] FLAG_PATTERN = 8'h7e;
    // Reset values
    localparam logic [7:0] RX_STATUS_RST = 8'h06;
    localparam logic [7:0] BYTE_RST      = 8'h00;
    localparam logic [3:0] IRQ_RST       = 4'h0;
endpackage : scrr_pkg

/* File: core/scrr_regs.sv */
// Function
// - Vector read via second channel returns vector with status merged in.
// - Vector read via first channel returns the stored vector unchanged.
// - Pending summary: first channel flags bits 5..3, second channel bits 2..0.
// - Pending summary reads all zero when accessed through the second channel.
// - With bit 6 set, mode readback returns last written mode configuration.
// - Sync field: 00 8-bit, 01 16-bit, 10 framed flag, 11 external.
// - Mode readback bit 1: 0 odd parity, 1 even parity.
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module scrr_regs (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Status from the channel logic
    input  wire logic [7:0]  rx_condition_in,
    input  wire logic [5:0]  pending_flag,
    // Decoded configuration
    output logic      [1:0]  sync_mode,
    output logic             parity_even,
    // Interrupt
    output logic             irq
);
    import scrr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] rx_status_reg;
    logic [7:0] vector_reg;
    logic [7:0] mode_reg;
    logic [7:0] ext_ctrl_reg;
    logic       chan_b_reg;
    logic [3:0] irq_status_reg;
    logic [3:0] irq_mask_reg;
    logic [5:0] pend_s1_reg;
    logic [5:0] pend_s2_reg;
    logic [5:0] pend_s3_reg;
    logic [5:0] pend_reg;
    logic [7:0] vector_mod;
    logic       setup;
    logic       wr_acc;
    logic       rd_acc;
    logic       mapped;
    logic [31:0] rdata_next;
    logic [3:0] irq_set;

    assign setup  = psel && !penable;
    assign wr_acc = setup && pwrite;
    assign rd_acc = setup && !pwrite;

    scrr_vec_mod u_vec (
        .vector_in  (vector_reg),
        .pending_in (pend_reg),
        .vector_out (vector_mod)
    );

    ////////////////////////////////////////////////////////////////////////
    // Pins from other logic are asynchronous: three stages, change when 2 and 3 agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_s1_reg <= BYTE_RST[5:0];
            pend_s2_reg <= BYTE_RST[5:0];
            pend_s3_reg <= BYTE_RST[5:0];
        end else begin
            pend_s1_reg <= pending_flag;
            pend_s2_reg <= pend_s1_reg;
            pend_s3_reg <= pend_s2_reg;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : g_pend
            // Each flag moves alone; a bit whose stages still disagree keeps its old value
            logic flag_reg;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    flag_reg <= 1'b0;
                end else if (pend_s2_reg[g] == pend_s3_reg[g]) begin
                    flag_reg <= pend_s3_reg[g];
                end
            end
            assign pend_reg[g] = flag_reg;
        end
    endgenerate

    // Receive condition status sampled each cycle; reads never clear it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_status_reg <= RX_STATUS_RST;
        end else begin
            rx_status_reg <= rx_condition_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vector_reg   <= BYTE_RST;
            mode_reg     <= BYTE_RST;
            ext_ctrl_reg <= BYTE_RST;
            chan_b_reg   <= 1'b0;
            irq_mask_reg <= IRQ_RST;
        end else if (wr_acc) begin
            if (paddr == ADDR_VECTOR_WR) begin
                vector_reg <= pwdata[7:0];
            end else if (paddr == ADDR_MODE_WR) begin
                mode_reg <= pwdata[7:0];
            end else if (paddr == ADDR_EXT_CTRL) begin
                ext_ctrl_reg <= pwdata[7:0];
            end else if (paddr == ADDR_CHAN_SEL) begin
                chan_b_reg <= pwdata[0];
            end else if (paddr == ADDR_IRQ_MASK) begin
                irq_mask_reg <= pwdata[3:0];
            end
        end
    end

    // Events: rx error bits rising, any pending flag rising
    logic [5:0] pend_d_reg;
    logic [3:0] rx_d_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_d_reg <= BYTE_RST[5:0];
            rx_d_reg   <= IRQ_RST;
        end else begin
            pend_d_reg <= pend_reg;
            rx_d_reg   <= rx_status_reg[7:4];
        end
    end
    assign irq_set = {|(rx_status_reg[7:4] & ~rx_d_reg),
                      |(pend_reg[5:3] & ~pend_d_reg[5:3]),
                      |(pend_reg[2:0] & ~pend_d_reg[2:0]),
                      1'b0};

    // Set wins over a write-one-to-clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_reg <= IRQ_RST;
        end else if (wr_acc && paddr == ADDR_IRQ_STATUS) begin
            irq_status_reg <= (irq_status_reg & ~pwdata[3:0]) | irq_set;
        end else begin
            irq_status_reg <= irq_status_reg | irq_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status_reg & irq_mask_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux: purely combinational, no side effects on any state
    always_comb begin
        rdata_next = 32'h0;
        mapped     = 1'b1;
        if (paddr == ADDR_RX_STATUS) begin
            rdata_next[7:0] = rx_status_reg;
        end else if (paddr == ADDR_VECTOR) begin
            if (chan_b_reg) begin
                rdata_next[7:0] = vector_mod;
            end else begin
                rdata_next[7:0] = vector_reg;
            end
        end else if (paddr == ADDR_PENDING) begin
            if (!chan_b_reg) begin
                rdata_next[PEND_A_LSB +: 3] = pend_reg[5:3];
                rdata_next[PEND_B_LSB +: 3] = pend_reg[2:0];
            end
            // Second channel leaves all bits zero
        end else if (paddr == ADDR_MODE_RB) begin
            if (ext_ctrl_reg[EXT_RB_BIT]) begin
                rdata_next[7:0] = mode_reg;
            end
        end else if (paddr == ADDR_VECTOR_WR) begin
            rdata_next[7:0] = vector_reg;
        end else if (paddr == ADDR_MODE_WR) begin
            rdata_next[7:0] = BYTE_RST; // Write-only; read back through mode readback
        end else if (paddr == ADDR_EXT_CTRL) begin
            rdata_next[7:0] = ext_ctrl_reg;
        end else if (paddr == ADDR_CHAN_SEL) begin
            rdata_next[0] = chan_b_reg;
        end else if (paddr == ADDR_IRQ_STATUS) begin
            rdata_next[3:0] = irq_status_reg;
        end else if (paddr == ADDR_IRQ_MASK) begin
            rdata_next[3:0] = irq_mask_reg;
        end else begin
            mapped = 1'b0;
        end
    end

    // No wait state: answer in the first access-phase cycle after setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup && !mapped;
            if (rd_acc) begin
                prdata <= rdata_next;
            end
        end
    end

    // Decoded configuration outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_mode   <= SYNC_8BIT;
            parity_even <= 1'b0;
        end else begin
            sync_mode   <= mode_reg[MODE_SYNC_LSB +: 2];
            parity_even <= mode_reg[MODE_PAR_SENSE];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks on reads, decoded outputs and interrupts; each watches only what this block drives
    logic rd_seen_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_seen_reg <= 1'b0;
        end else begin
            rd_seen_reg <= rd_acc;
        end
    end

    // Bus timing
    ready_after_setup_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        setup |=> pready)
        else $error("no answer in the cycle after setup");
    err_with_ready_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("error flag without ready");
    unmapped_zero_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        rd_acc && !mapped |=> prdata == 32'h0 && pslverr)
        else $error("unmapped read returned data");
    mode_wr_hidden_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        rd_acc && paddr == ADDR_MODE_WR |=> prdata == 32'h0)
        else $error("mode write register read back directly");

    // Pending summary
    pend_b_zero_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        rd_acc && paddr == ADDR_PENDING && chan_b_reg |=> prdata == 32'h0)
        else $error("pending summary nonzero via second channel");
    pend_a_map_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        rd_acc && paddr == ADDR_PENDING && !chan_b_reg
        |=> prdata[5:0] == $past(pend_reg) && prdata[31:6] == 26'h0)
        else $error("pending summary layout wrong");
    pend_settle_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        ((pend_reg ^ $past(pend_reg)) & $past(pend_s2_reg ^ pend_s3_reg)) == 6'h00)
        else $error("pending flag taken before its stages agreed");

    // Interrupt vector
    vec_raw_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        rd_acc && paddr == ADDR_VECTOR && !chan_b_reg |=> prdata[7:0] == $past(vector_reg))
        else $error("first channel vector modified");
    vec_mod_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        rd_acc && paddr == ADDR_VECTOR && chan_b_reg && pend_reg[5]
        |=> prdata[3:1] == 3'h6 && prdata[7:4] == $past(vector_reg[7:4]))
        else $error("second channel vector lacks status");
    vec_idle_code_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        rd_acc && paddr == ADDR_VECTOR && chan_b_reg && pend_reg == 6'h00
        |=> prdata[3:1] == 3'h3 && prdata[0] == $past(vector_reg[0]))
        else $error("idle code missing from second channel vector");
    vec_low_code_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        rd_acc && paddr == ADDR_VECTOR && chan_b_reg && pend_reg == 6'h01
        |=> prdata[3:1] == 3'h1)
        else $error("lowest source code wrong in second channel vector");

    // Mode readback and decoded configuration
    mode_gate_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        rd_acc && paddr == ADDR_MODE_RB && !ext_ctrl_reg[EXT_RB_BIT] |=> prdata == 32'h0)
        else $error("mode readback visible while disabled");
    mode_rb_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        rd_acc && paddr == ADDR_MODE_RB && ext_ctrl_reg[EXT_RB_BIT]
        |=> prdata[7:0] == $past(mode_reg) && prdata[31:8] == 24'h0)
        else $error("mode readback mismatch");
    sync_field_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        $changed(mode_reg) |=> ##1 sync_mode == $past(mode_reg[5:4], 2))
        else $error("sync mode field not decoded");
    sync_frame_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        mode_reg[MODE_SYNC_LSB +: 2] == SYNC_FRAME |=> sync_mode == SYNC_FRAME)
        else $error("framed sync mode not decoded");
    parity_sense_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        ##1 parity_even == $past(mode_reg[MODE_PAR_SENSE]))
        else $error("parity sense wrong");

    // Reads have no side effects, so interrupt status keeps its history until software clears it
    read_stable_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        rd_seen_reg |-> $stable(vector_reg) && $stable(mode_reg) && $stable(ext_ctrl_reg)
            && $stable(chan_b_reg) && $stable(irq_mask_reg))
        else $error("read altered stored state");
    irq_read_keep_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        rd_acc && paddr == ADDR_IRQ_STATUS
        |=> (irq_status_reg & $past(irq_status_reg)) == $past(irq_status_reg))
        else $error("reading interrupt status cleared a bit");
    rx_follow_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        ##1 rx_status_reg == $past(rx_condition_in))
        else $error("receive status not refreshed from the channel");

    // Interrupt status and output
    set_wins_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        irq_set != 4'h0 |=> (irq_status_reg & $past(irq_set)) == $past(irq_set))
        else $error("interrupt event lost to a clear");
    irq_level_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        ##1 irq == $past(|(irq_status_reg & irq_mask_reg)))
        else $error("interrupt output does not follow masked status");
endmodule : scrr_regs
`default_nettype wire

/* File: core/scrr_vec_mod.sv */
`timescale 1ns/10ps
`default_nettype none
// Folds the highest-priority pending source into vector bits 3:1
module scrr_vec_mod (
    // Inputs
    input  wire logic [7:0] vector_in,
    input  wire logic [5:0] pending_in,
    // Result
    output logic      [7:0] vector_out
);
    import scrr_pkg::*;
    logic [2:0] code;
    always_comb begin
        code = 3'h3;
        if (pending_in[5])      code = 3'h6;
        else if (pending_in[4]) code = 3'h4;
        else if (pending_in[3]) code = 3'h5;
        else if (pending_in[2]) code = 3'h2;
        else if (pending_in[1]) code = 3'h0;
        else if (pending_in[0]) code = 3'h1;
        vector_out = {vector_in[7:4], code, vector_in[0]};
    end
endmodule : scrr_vec_mod
`default_nettype wire

/* File: tb/scrr_chan_model.sv */
`timescale 1ns/10ps
`default_nettype none
module scrr_chan_model (
    // Clock
    input  wire logic       pclk,
    // Values commanded by the bench
    input  wire logic [7:0] rx_cmd,
    input  wire logic [5:0] pend_cmd,
    // Towards the register block
    output logic      [7:0] rx_condition_in,
    output logic      [5:0] pending_flag
);
    // Flags move just after an edge, as a synchronous channel engine would
    always_ff @(posedge pclk) begin
        rx_condition_in <= rx_cmd;
        pending_flag    <= pend_cmd;
    end
endmodule : scrr_chan_model
`default_nettype wire

/* File: tb/tb_scrr_regs.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_scrr_regs;
    import scrr_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, parity_even, irq, err;
    logic [7:0]  paddr, rx_cmd, rx_condition_in, vec, mode;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0]  pend_cmd, pending_flag, p;
    logic [1:0]  sync_mode;
    int          mismatches, checks_done, i;
    integer      seed;
    //////////////////////////////////////////////////////////////////////////
    scrr_regs scrr_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_condition_in(rx_condition_in), .pending_flag(pending_flag),
        .sync_mode(sync_mode), .parity_even(parity_even), .irq(irq));
    scrr_chan_model scrr_chan_model_inst (.pclk(pclk), .rx_cmd(rx_cmd), .pend_cmd(pend_cmd),
        .rx_condition_in(rx_condition_in), .pending_flag(pending_flag));
    always #5 pclk = ~pclk;
    //////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Request stands until pready is seen high at a rising edge; the answer is taken at that edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            mismatches++;
            tally_and_finish();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic setp(input logic [5:0] v);
        pend_cmd <= v;
        repeat (8) @(posedge pclk);
    endtask : setp
    // Outputs are looked at mid-cycle, once settled; sel 0 sync_mode, 1 parity_even, 2 irq
    task automatic chk_out(input string what, input int sel, input logic [31:0] exp);
        logic [31:0] seen_now;
        @(negedge pclk);
        seen_now = (sel == 0) ? {30'h0, sync_mode} : (sel == 1) ? {31'h0, parity_even} : {31'h0, irq};
        check(what, seen_now, exp);
        @(posedge pclk);
    endtask : chk_out
    function automatic logic [7:0] merged(input logic [7:0] v, input logic [5:0] f);
        logic [2:0] c;
        c = f[5] ? 3'h6 : f[4] ? 3'h4 : f[3] ? 3'h5 : f[2] ? 3'h2 : f[1] ? 3'h0 : f[0] ? 3'h1 : 3'h3;
        return {v[7:4], c, v[0]};
    endfunction : merged
    task automatic tally_and_finish;
        $display("checks_done %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish
    //////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        mismatches++;
        tally_and_finish();
    end
    initial begin
        pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; rx_cmd = 8'h06; pend_cmd = 6'h00;
        mismatches = 0; checks_done = 0; seed = 32'hddd81343;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, ADDR_RX_STATUS, 32'h0); check("rx_status", rd, 32'h06);
        apb(1'b0, 8'h3c, 32'h0); check("unmapped_err", {31'h0, err}, 32'h1);
        check("unmapped_data", rd, 32'h0);
        // One-hot pending patterns first, then random mixes
        for (i = 0; i < 12; i++) begin
            p = (i < 6) ? 6'h01 << i : 6'($random(seed));
            vec = 8'($random(seed));
            rx_cmd <= 8'($random(seed));
            setp(p);
            apb(1'b1, ADDR_VECTOR_WR, {24'h0, vec});
            apb(1'b1, ADDR_CHAN_SEL, 32'h0);
            apb(1'b0, ADDR_VECTOR, 32'h0); check("vector_a", rd, {24'h0, vec});
            apb(1'b0, ADDR_RX_STATUS, 32'h0); check("rx_status_rnd", rd, {24'h0, rx_cmd});
            apb(1'b0, ADDR_PENDING, 32'h0); check("pending_a", rd, {26'h0, p});
            apb(1'b0, ADDR_PENDING, 32'h0); check("pending_again", rd, {26'h0, p});
            apb(1'b1, ADDR_CHAN_SEL, 32'h1);
            apb(1'b0, ADDR_VECTOR, 32'h0); check("vector_b", rd, {24'h0, merged(vec, p)});
            apb(1'b0, ADDR_PENDING, 32'h0); check("pending_b", rd, 32'h0);
            setp(6'h00);
        end
        apb(1'b0, ADDR_VECTOR, 32'h0); check("vector_idle", rd, {24'h0, merged(vec, 6'h00)});
        for (i = 0; i < 8; i++) begin
            mode = 8'($random(seed));
            mode[5:4] = i[1:0];
            apb(1'b1, ADDR_MODE_WR, {24'h0, mode});
            apb(1'b1, ADDR_EXT_CTRL, (i < 4) ? 32'h40 : 32'h0);
            apb(1'b0, ADDR_MODE_RB, 32'h0); check("mode_rb", rd, (i < 4) ? {24'h0, mode} : 32'h0);
            chk_out("sync_mode", 0, {30'h0, mode[5:4]});
            chk_out("parity_even", 1, {31'h0, mode[1]});
        end
        // Interrupt: raise masked and unmasked, read without clearing, then clear
        rx_cmd <= 8'h00;
        setp(6'h00);
        apb(1'b1, ADDR_IRQ_STATUS, 32'hf);
        apb(1'b1, ADDR_IRQ_MASK, 32'h2);
        apb(1'b0, ADDR_IRQ_STATUS, 32'h0); check("irq_status_clr", rd, 32'h0);
        setp(6'h20);
        apb(1'b0, ADDR_IRQ_STATUS, 32'h0); check("irq_status_a", rd, 32'h4);
        chk_out("irq_masked", 2, 32'h0);
        setp(6'h00);
        setp(6'h01);
        apb(1'b0, ADDR_IRQ_STATUS, 32'h0); check("irq_status_ab", rd, 32'h6);
        apb(1'b0, ADDR_IRQ_STATUS, 32'h0); check("irq_status_kept", rd, 32'h6);
        chk_out("irq_high", 2, 32'h1);
        apb(1'b1, ADDR_IRQ_STATUS, 32'h2);
        rx_cmd <= 8'h10;
        setp(6'h01);
        apb(1'b0, ADDR_IRQ_STATUS, 32'h0); check("irq_status_rx", rd, 32'hc);
        chk_out("irq_low", 2, 32'h0);
        apb(1'b1, ADDR_IRQ_MASK, 32'hf);
        chk_out("irq_unmasked", 2, 32'h1);
        // Reset in mid-run with quiet inputs: every stored value must fall back
        rx_cmd <= 8'h06;
        setp(6'h00);
        presetn <= 1'b0;
        chk_out("irq_in_reset", 2, 32'h0);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, ADDR_IRQ_STATUS, 32'h0); check("irq_status_rst", rd, 32'h0);
        apb(1'b0, ADDR_IRQ_MASK, 32'h0); check("irq_mask_rst", rd, 32'h0);
        apb(1'b0, ADDR_CHAN_SEL, 32'h0); check("chan_sel_rst", rd, 32'h0);
        apb(1'b0, ADDR_VECTOR_WR, 32'h0); check("vector_rst", rd, 32'h0);
        apb(1'b0, ADDR_MODE_RB, 32'h0); check("mode_rb_rst", rd, 32'h0);
        apb(1'b0, ADDR_RX_STATUS, 32'h0); check("rx_status_rst", rd, 32'h06);
        chk_out("sync_mode_rst", 0, 32'h0);
        chk_out("parity_rst", 1, 32'h0);
        tally_and_finish();
    end
endmodule : tb_scrr_regs
`default_nettype wire
